/* File: pkg/pdsap_cfg.svh */
// Constants of the source attach policy block: timing, limits, trim codes, register map.
// Assumes a 10 MHz system clock; included by the policy module and the bench.
`ifndef PDSAP_CFG_SVH
`define PDSAP_CFG_SVH
`define PDSAP_CLK_HZ        10000000
`define PDSAP_DEBOUNCE_US   100
`define PDSAP_NO_RESP_MS    150
`define PDSAP_VSAFE_MIN_MV  16'd4750
`define PDSAP_VSAFE_MAX_MV  16'd5500
`define PDSAP_V5_MV         16'd5000
`define PDSAP_PPS_MIN_MV    16'd3300
`define PDSAP_PPS_MAX_MV    16'd21000
`define PDSAP_MA_3A         13'd3000
`define PDSAP_MA_5A         13'd5000
`define PDSAP_PDP_MIN_W     7'd16
`define PDSAP_PDP_MAX_W     7'd100
`define PDSAP_PDP_DEF_W     7'd60
`define PDSAP_COMP_DEF      2'd0
`define PDSAP_OVP_DEF       2'd1
`define PDSAP_FB_DIV        16'd10
`define PDSAP_DRIVE_MAX     10'h3FF
`define PDSAP_REG_STATUS    5'h0
`define PDSAP_REG_IRQ_STAT  5'h4
`define PDSAP_REG_IRQ_MASK  5'h8
`define PDSAP_REG_TRIM      5'hC
`define PDSAP_REG_CONTRACT  5'h10
`define PDSAP_REG_CTRL      5'h14
`define PDSAP_IRQ_ATTACH    0
`define PDSAP_IRQ_DETACH    1
`define PDSAP_IRQ_FAULT     2
`define PDSAP_IRQ_TYPEC     3
`define PDSAP_IRQ_PPS       4
`define PDSAP_IRQ_W         5
`endif

/* File: pkg/pdsap_pkg.sv */
// Types shared by the source attach policy block.
// Assumes pdsap_cfg.svh is on the include path.
package pdsap_pkg;
  typedef enum logic [5:0] {
    ST_DETACHED = 6'b000001,
    ST_DEBOUNCE = 6'b000010,
    ST_PD_WAIT  = 6'b000100,
    ST_PD_ACT   = 6'b001000,
    ST_TYPEC    = 6'b010000,
    ST_FAULT    = 6'b100000
  } pdsap_state_t;
  typedef enum logic [2:0] {
    AD_IDLE   = 3'b001,
    AD_WAIT_I = 3'b010,
    AD_WAIT_V = 3'b100
  } pdsap_adc_t;
  typedef enum logic [1:0] {
    EV_NONE = 2'h0, EV_REQ_FIXED = 2'h1, EV_REQ_PPS = 2'h2, EV_PPS_STATUS = 2'h3
  } pdsap_evt_t;
  typedef enum logic [1:0] {
    LG_NONE = 2'h0, LG_BC_SHORT = 2'h1, LG_DIVIDER = 2'h2
  } pdsap_legacy_t;
endpackage

/* File: verilog/pdsap_policy.sv */
// Attach, contract and supply policy of a Type-C / PD source, with an Avalon-MM register slave.
// Assumes all inputs are synchronous to sys_clk_in; analog values arrive as digital codes.
//
// Summary of operation
// - Keep load switch off until a valid sink attach is seen on CC.
// - Powered by back-fed VBUS, stay detached without a sink termination.
// - Silent sink after attach gets plain 5 V until it detaches.
// - Drive feedback output from contract target and sensed feedback voltage.
// - In PPS contract, answer status request with 10-bit current sample.
// - Reported voltage is sampled from supply sense, never from feedback input.
// - Current drives OCP in fixed, limiting in PPS, and cable compensation.
// - With divider option, detect legacy sink kind and present its signature.
// - Legacy sinks get 5 V with up to 3 A allowance.
// - Advertise capabilities and answer PD requests with no host help.
// - Port power trim 16 W to 100 W in 1 W steps, default 60 W.
// - Cable compensation trim: disabled, 50, 100 or 150 mV/A.
// - High-current trim: 3 A without marker, or 5 A needing marker.
// - Over-voltage trim: 115, 120, 125 or 130 percent, default 120.
// - Trims are fixed; no runtime path alters them.
// - Refuse attach until supply sense is within 4.75 V to 5.5 V.
// - Pull up both CC lines with the 3 A advertisement current.
`timescale 1ns/1ps
`include "pdsap_cfg.svh"
`default_nettype none
module pdsap_policy #(
  parameter int unsigned NO_RESP_CYC = `PDSAP_NO_RESP_MS * (`PDSAP_CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_n_in,
  // Avalon-MM slave
  input  wire logic [4:0]             avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out,
  output logic                        irq_out,
  // Fuse trims
  input  wire logic [6:0]             trim_pdp_w_in,
  input  wire logic [1:0]             trim_cable_comp_in,
  input  wire logic                   trim_5a_in,
  input  wire logic [1:0]             trim_ovp_in,
  input  wire logic                   trim_legacy_div_in,
  // Port sensing and control
  input  wire logic [1:0]             cc_rd_in,
  output logic [1:0]                  cc_pullup_3a_out,
  input  wire logic [15:0]            vcc_mv_in,
  input  wire logic [15:0]            voltage_feedback_input,
  input  wire logic [12:0]            current_sense_pos,
  input  wire logic [12:0]            current_sense_neg,
  output logic [9:0]                  feedback_drive_output,
  output logic                        vbus_load_switch,
  input  wire logic                   dp_probe_in,
  output pdsap_pkg::pdsap_legacy_t    legacy_sig_out,
  // PD message engine
  input  wire logic                   pd_sink_resp_in,
  input  wire logic                   pd_cable_5a_in,
  input  wire logic                   pd_evt_valid_in,
  input  wire pdsap_pkg::pdsap_evt_t  pd_evt_type_in,
  input  wire logic [15:0]            pd_req_mv_in,
  input  wire logic [12:0]            pd_req_ma_in,
  output logic                        pd_src_caps_out,
  output logic                        pd_accept_out,
  output logic                        pd_reject_out,
  output logic [6:0]                  pd_adv_pdp_w_out,
  output logic [12:0]                 pd_adv_max_ma_out,
  // Converter and status reply
  output logic                        adc_start_out,
  output logic                        adc_chan_vcc_out,
  input  wire logic                   adc_done_in,
  input  wire logic [9:0]             adc_data_in,
  output logic                        pps_reply_valid_out,
  output logic [9:0]                  pps_reply_curr_out,
  output logic [9:0]                  pps_reply_volt_out
);
  import pdsap_pkg::*;

  localparam int unsigned DEB_CYC =
    (`PDSAP_DEBOUNCE_US * (`PDSAP_CLK_HZ / 1000000) < 1) ? 1 :
    `PDSAP_DEBOUNCE_US * (`PDSAP_CLK_HZ / 1000000);
  // The no-response timer is 24 bits wide and needs at least two counts.
  if (NO_RESP_CYC < 2 || NO_RESP_CYC > 32'h00FFFFFF) begin : g_bad_no_resp
    $error("NO_RESP_CYC out of range");
  end

  function automatic logic [23:0] pct_of(input logic [15:0] mv, input logic [7:0] pct);
    pct_of = 24'(mv) * 24'(pct);
  endfunction

  // ****************************************************************
  // Trim capture
  // ****************************************************************
  logic       trim_cap_q;
  logic [6:0] trim_pdp_q;
  logic [1:0] trim_comp_q;
  logic       trim_5a_q;
  logic [1:0] trim_ovp_q;
  logic       trim_leg_q;
  // Fuses are read once after reset; nothing in the bus path can write these.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trim_cap_q  <= 1'b0;
      trim_pdp_q  <= `PDSAP_PDP_DEF_W;
      trim_comp_q <= `PDSAP_COMP_DEF;
      trim_5a_q   <= 1'b0;
      trim_ovp_q  <= `PDSAP_OVP_DEF;
      trim_leg_q  <= 1'b0;
    end else if (!trim_cap_q) begin
      trim_cap_q  <= 1'b1;
      // An out-of-range power code falls back to the default.
      trim_pdp_q  <= (trim_pdp_w_in < `PDSAP_PDP_MIN_W || trim_pdp_w_in > `PDSAP_PDP_MAX_W) ?
                     `PDSAP_PDP_DEF_W : trim_pdp_w_in;
      trim_comp_q <= trim_cable_comp_in;
      trim_5a_q   <= trim_5a_in;
      trim_ovp_q  <= trim_ovp_in;
      trim_leg_q  <= trim_legacy_div_in;
    end
  end

  // ****************************************************************
  // Derived limits
  // ****************************************************************
  logic [12:0] i_ma;
  logic [12:0] max_ma;
  logic [7:0]  ovp_pct;
  logic [7:0]  comp_k;
  logic        rd_any;
  logic        vcc_ok;
  always_comb begin
    i_ma    = (current_sense_pos > current_sense_neg) ? current_sense_pos - current_sense_neg
                                                      : 13'h0000;
    max_ma  = (trim_5a_q && pd_cable_5a_in) ? `PDSAP_MA_5A : `PDSAP_MA_3A;
    unique case (trim_ovp_q)
      2'h0:    ovp_pct = 8'd115;
      2'h1:    ovp_pct = 8'd120;
      2'h2:    ovp_pct = 8'd125;
      default: ovp_pct = 8'd130;
    endcase
    unique case (trim_comp_q)
      2'h1:    comp_k = 8'd50;
      2'h2:    comp_k = 8'd100;
      2'h3:    comp_k = 8'd150;
      default: comp_k = 8'd0;
    endcase
    rd_any = cc_rd_in[0] ^ cc_rd_in[1];
    vcc_ok = vcc_mv_in >= `PDSAP_VSAFE_MIN_MV && vcc_mv_in <= `PDSAP_VSAFE_MAX_MV;
  end
  assign cc_pullup_3a_out  = 2'b11;
  assign pd_adv_pdp_w_out  = trim_pdp_q;
  assign pd_adv_max_ma_out = max_ma;

  // ****************************************************************
  // Attach and contract state machine
  // ****************************************************************
  pdsap_state_t state_q, state_d;
  logic [23:0]  tmr_q;
  logic [15:0]  tgt_mv_q;
  logic [12:0]  op_ma_q;
  logic         pps_q;
  logic         ctrl_dis_q;
  logic         ocp;
  logic         ovp;
  logic         req_ok;
  logic         req_evt;
  always_comb begin
    ocp     = !pps_q && i_ma > op_ma_q;
    ovp     = pct_of(vcc_mv_in, 8'd100) > pct_of(tgt_mv_q, ovp_pct);
    req_evt = pd_evt_valid_in && (pd_evt_type_in == EV_REQ_FIXED || pd_evt_type_in == EV_REQ_PPS);
    req_ok  = pd_req_ma_in <= max_ma && pd_req_mv_in >= `PDSAP_PPS_MIN_MV &&
              pd_req_mv_in <= `PDSAP_PPS_MAX_MV;
    state_d = state_q;
    unique case (state_q)
      ST_DETACHED: if (trim_cap_q && !ctrl_dis_q && vcc_ok && rd_any) state_d = ST_DEBOUNCE;
      ST_DEBOUNCE: begin
        if (!rd_any || !vcc_ok || ctrl_dis_q) state_d = ST_DETACHED;
        else if (tmr_q == 24'(DEB_CYC - 1)) state_d = ST_PD_WAIT;
      end
      ST_PD_WAIT: begin
        if (!rd_any || ctrl_dis_q) state_d = ST_DETACHED;
        else if (ocp || ovp) state_d = ST_FAULT;
        else if (pd_sink_resp_in) state_d = ST_PD_ACT;
        else if (tmr_q == 24'(NO_RESP_CYC - 1)) state_d = ST_TYPEC;
      end
      ST_PD_ACT: begin
        if (!rd_any || ctrl_dis_q) state_d = ST_DETACHED;
        else if (ocp || ovp) state_d = ST_FAULT;
      end
      ST_TYPEC: begin
        if (!rd_any || ctrl_dis_q) state_d = ST_DETACHED;
        else if (ocp || ovp) state_d = ST_FAULT;
      end
      ST_FAULT: if (!rd_any) state_d = ST_DETACHED;
      default:  state_d = ST_DETACHED;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q          <= ST_DETACHED;
      tmr_q            <= 24'h000000;
      vbus_load_switch <= 1'b0;
      pd_src_caps_out  <= 1'b0;
    end else begin
      state_q          <= state_d;
      tmr_q            <= (state_d != state_q) ? 24'h000000 : tmr_q + 24'h000001;
      vbus_load_switch <= state_d == ST_PD_WAIT || state_d == ST_PD_ACT || state_d == ST_TYPEC;
      pd_src_caps_out  <= state_q == ST_DEBOUNCE && state_d == ST_PD_WAIT;
    end
  end

  // Contract: 5 V at 3 A until the sink asks for more; legacy sinks stay here.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgt_mv_q      <= `PDSAP_V5_MV;
      op_ma_q       <= `PDSAP_MA_3A;
      pps_q         <= 1'b0;
      pd_accept_out <= 1'b0;
      pd_reject_out <= 1'b0;
    end else begin
      pd_accept_out <= state_q == ST_PD_ACT && req_evt && req_ok;
      pd_reject_out <= state_q == ST_PD_ACT && req_evt && !req_ok;
      if (state_q != ST_PD_ACT) begin
        tgt_mv_q <= `PDSAP_V5_MV;
        op_ma_q  <= `PDSAP_MA_3A;
        pps_q    <= 1'b0;
      end else if (req_evt && req_ok) begin
        tgt_mv_q <= pd_req_mv_in;
        op_ma_q  <= pd_req_ma_in;
        pps_q    <= pd_evt_type_in == EV_REQ_PPS;
      end
    end
  end

  // ****************************************************************
  // Feedback drive
  // ****************************************************************
  // More drive pulls the supply down. Cable drop is added before the divider.
  logic [15:0] comp_mv;
  logic [15:0] fb_ref;
  logic        too_high;
  always_comb begin
    comp_mv  = 16'((21'(i_ma) * 21'(comp_k)) / 21'd1000);
    fb_ref   = 16'((17'(tgt_mv_q) + 17'(comp_mv)) / 17'(`PDSAP_FB_DIV));
    too_high = voltage_feedback_input > fb_ref || (pps_q && i_ma > op_ma_q);
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      feedback_drive_output <= 10'h000;
    end else if (too_high && feedback_drive_output != `PDSAP_DRIVE_MAX) begin
      feedback_drive_output <= feedback_drive_output + 10'h001;
    end else if (!too_high && feedback_drive_output != 10'h000) begin
      feedback_drive_output <= feedback_drive_output - 10'h001;
    end
  end

  // ****************************************************************
  // Status request sampling
  // ****************************************************************
  pdsap_adc_t adc_q;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      adc_q               <= AD_IDLE;
      adc_start_out       <= 1'b0;
      adc_chan_vcc_out    <= 1'b0;
      pps_reply_valid_out <= 1'b0;
      pps_reply_curr_out  <= 10'h000;
      pps_reply_volt_out  <= 10'h000;
    end else begin
      adc_start_out       <= 1'b0;
      pps_reply_valid_out <= 1'b0;
      unique case (adc_q)
        AD_IDLE: if (state_q == ST_PD_ACT && pps_q && pd_evt_valid_in &&
                     pd_evt_type_in == EV_PPS_STATUS) begin
          adc_q            <= AD_WAIT_I;
          adc_start_out    <= 1'b1;
          adc_chan_vcc_out <= 1'b0;
        end
        AD_WAIT_I: if (adc_done_in) begin
          pps_reply_curr_out <= adc_data_in;
          adc_q              <= AD_WAIT_V;
          adc_start_out      <= 1'b1;
          adc_chan_vcc_out   <= 1'b1;
        end
        AD_WAIT_V: if (adc_done_in) begin
          pps_reply_volt_out  <= adc_data_in;
          pps_reply_valid_out <= 1'b1;
          adc_q               <= AD_IDLE;
        end
        default: adc_q <= AD_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Legacy charging signature
  // ****************************************************************
  // A sink running primary detection sees the short; others get the divider.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      legacy_sig_out <= LG_NONE;
    end else if (!trim_leg_q || !vbus_load_switch) begin
      legacy_sig_out <= LG_NONE;
    end else begin
      legacy_sig_out <= dp_probe_in ? LG_BC_SHORT : LG_DIVIDER;
    end
  end

  // ****************************************************************
  // Registers and interrupt
  // ****************************************************************
  logic [`PDSAP_IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic                    ack_q;
  logic                    wr_go;
  always_comb begin
    irq_set = '0;
    irq_set[`PDSAP_IRQ_ATTACH] = state_q == ST_DEBOUNCE && state_d == ST_PD_WAIT;
    irq_set[`PDSAP_IRQ_DETACH] = state_q != ST_DETACHED && state_d == ST_DETACHED;
    irq_set[`PDSAP_IRQ_FAULT]  = state_q != ST_FAULT && state_d == ST_FAULT;
    irq_set[`PDSAP_IRQ_TYPEC]  = state_q == ST_PD_WAIT && state_d == ST_TYPEC;
    irq_set[`PDSAP_IRQ_PPS]    = pps_reply_valid_out;
  end
  // One wait cycle: the request is taken at the second edge it is seen.
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
  assign wr_go               = avs_write_in && ack_q;
  assign irq_out             = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q            <= 1'b0;
      avs_readdata_out <= 32'h00000000;
      irq_stat_q       <= '0;
      irq_mask_q       <= '0;
      ctrl_dis_q       <= 1'b0;
    end else begin
      ack_q <= (avs_read_in || avs_write_in) && !ack_q;
      // A new event wins over a same-cycle write-one clear.
      irq_stat_q <= (irq_stat_q & ~((wr_go && avs_address_in == `PDSAP_REG_IRQ_STAT) ?
                    avs_writedata_in[`PDSAP_IRQ_W-1:0] : '0)) | irq_set;
      if (wr_go && avs_address_in == `PDSAP_REG_IRQ_MASK) irq_mask_q <= avs_writedata_in[`PDSAP_IRQ_W-1:0];
      if (wr_go && avs_address_in == `PDSAP_REG_CTRL) ctrl_dis_q <= avs_writedata_in[0];
      if (avs_read_in && !ack_q) begin
        unique case (avs_address_in)
          `PDSAP_REG_STATUS:   avs_readdata_out <= {18'h0, legacy_sig_out, adc_q != AD_IDLE,
                                                    pps_q, vbus_load_switch, vcc_ok, 2'h0,
                                                    state_q};
          `PDSAP_REG_IRQ_STAT: avs_readdata_out <= 32'(irq_stat_q);
          `PDSAP_REG_IRQ_MASK: avs_readdata_out <= 32'(irq_mask_q);
          `PDSAP_REG_TRIM:     avs_readdata_out <= {18'h0, trim_leg_q, trim_ovp_q, trim_5a_q,
                                                    trim_comp_q, 1'b0, trim_pdp_q};
          `PDSAP_REG_CONTRACT: avs_readdata_out <= {3'h0, op_ma_q, tgt_mv_q};
          `PDSAP_REG_CTRL:     avs_readdata_out <= {31'h0, ctrl_dis_q};
          default:             avs_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_switch_after_debounce: assert property ($rose(vbus_load_switch) |->
    $past(state_q) == ST_DEBOUNCE && $past(rd_any)) else $error("switch on without attach");
  a_stay_detached: assert property (state_q == ST_DETACHED && !rd_any |=>
    state_q == ST_DETACHED && !vbus_load_switch) else $error("left detached without sink");
  a_typec_hold_5v: assert property (state_q == ST_TYPEC && rd_any && !ctrl_dis_q && !ocp && !ovp
    |=> state_q == ST_TYPEC && tgt_mv_q == `PDSAP_V5_MV) else $error("fallback lost");
  a_fb_step_up: assert property (too_high && feedback_drive_output != `PDSAP_DRIVE_MAX |=>
    feedback_drive_output == $past(feedback_drive_output) + 10'h001) else $error("drive stuck");
  a_pps_curr_first: assert property (adc_q == AD_WAIT_I && adc_done_in |=>
    pps_reply_curr_out == $past(adc_data_in) && adc_start_out && adc_chan_vcc_out)
    else $error("reply without current sample");
  a_pps_volt_vcc: assert property (pps_reply_valid_out |->
    pps_reply_volt_out == $past(adc_data_in) && adc_chan_vcc_out) else $error("volt source");
  a_ocp_trip: assert property (state_q == ST_PD_ACT && rd_any && !ctrl_dis_q && ocp |=>
    state_q == ST_FAULT ##1 !vbus_load_switch) else $error("overcurrent missed");
  a_legacy_sig: assert property (trim_leg_q && vbus_load_switch && dp_probe_in |=>
    legacy_sig_out == LG_BC_SHORT) else $error("legacy signature");
  a_vcc_gate: assert property ($rose(state_q == ST_DEBOUNCE) |-> $past(vcc_ok))
    else $error("attach without safe 5 V");
  a_trim_hold: assert property (trim_cap_q && $past(trim_cap_q) |->
    $stable(trim_pdp_q) && $stable(trim_ovp_q) && $stable(trim_comp_q)) else $error("trim moved");
  c_pd_contract: cover property (state_q == ST_PD_WAIT ##1 state_q == ST_PD_ACT);
  c_typec_fallback: cover property (state_q == ST_PD_WAIT ##1 state_q == ST_TYPEC);
  c_pps_reply: cover property (pps_reply_valid_out);
  c_fault: cover property (state_q == ST_FAULT);
endmodule
`default_nettype wire

/* File: bench/pdsap_sink_model.sv */
// Sink at the far side of the port, plus the converter that the policy block starts.
// Assumes the policy block's clock and reset; conversion latency is set by the bench.
`timescale 1ns/1ps
`default_nettype none
module pdsap_sink_model (
  // Clock, reset and bench control
  input  wire logic       clk_in, rst_n_in, attach_in, both_rd_in, answer_in,
  input  wire logic [3:0] lat_in,
  input  wire logic [9:0] i_code_in, v_code_in,
  // Port and converter side
  input  wire logic       src_caps_in, adc_start_in, adc_chan_vcc_in,
  output logic [1:0]      cc_rd_out,
  output logic            resp_out, adc_done_out,
  output logic [9:0]      adc_data_out
);
  logic [4:0] cnt_q;
  logic       chan_q;
  assign cc_rd_out = attach_in ? (both_rd_in ? 2'h3 : 2'h1) : 2'h0;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_out <= 1'b0;
      adc_done_out <= 1'b0;
      adc_data_out <= 10'h0;
      cnt_q <= 5'h0;
      chan_q <= 1'b0;
    end else begin
      resp_out <= src_caps_in & answer_in;
      adc_done_out <= (cnt_q == 5'h1);
      // Data outside the done cycle toggles so a late sample cannot pass.
      adc_data_out <= (cnt_q == 5'h1) ? (chan_q ? v_code_in : i_code_in) : ~adc_data_out;
      if (adc_start_in) begin
        cnt_q <= {1'b0, lat_in} + 5'h1;
        chan_q <= adc_chan_vcc_in;
      end else if (cnt_q != 5'h0) begin
        cnt_q <= cnt_q - 5'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_pdsap_policy.sv */
// Self-checking bench of the source attach policy block.
// Assumes pdsap_pkg is compiled first and pdsap_cfg.svh is on the include path.
`timescale 1ns/1ps
`include "pdsap_cfg.svh"
`default_nettype none
module tb_pdsap_policy;
  import pdsap_pkg::*;
  localparam int NR = 200;
  logic sys_clk_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0;
  logic avs_waitrequest_out, irq_out, vbus_load_switch, pd_sink_resp_in, pd_evt_valid_in = 0;
  logic trim_5a_in = 1, trim_legacy_div_in = 1, dp_probe_in = 0, pd_cable_5a_in = 0;
  logic pd_src_caps_out, pd_accept_out, pd_reject_out, adc_start_out, adc_chan_vcc_out;
  logic adc_done_in, pps_reply_valid_out, attach = 0, both = 0, answer = 0;
  logic [4:0]  avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out, tv;
  logic [6:0]  trim_pdp_w_in, pd_adv_pdp_w_out;
  logic [1:0]  trim_cable_comp_in, trim_ovp_in, cc_rd_in, cc_pullup_3a_out;
  logic [15:0] vcc_mv_in = 16'd5000, voltage_feedback_input = 16'd500, pd_req_mv_in = 0;
  logic [12:0] current_sense_pos = 0, current_sense_neg = 0, pd_req_ma_in = 0;
  logic [12:0] pd_adv_max_ma_out;
  logic [9:0]  feedback_drive_output, adc_data_in, pps_reply_curr_out, pps_reply_volt_out;
  logic [9:0]  i_code = 0, v_code = 0, d;
  logic [3:0]  lat = 0;
  pdsap_legacy_t legacy_sig_out;
  pdsap_evt_t    pd_evt_type_in = EV_NONE;
  int mismatches = 0, tests_run = 0, cyc = 0, n;
  logic [31:0] rd_q[$];
  logic [19:0] pps_q[$];
  always #50 sys_clk_in = ~sys_clk_in;
  pdsap_policy #(.NO_RESP_CYC(NR)) u_dut (.sys_clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .irq_out,
    .trim_pdp_w_in, .trim_cable_comp_in, .trim_5a_in, .trim_ovp_in, .trim_legacy_div_in,
    .cc_rd_in, .cc_pullup_3a_out, .vcc_mv_in, .voltage_feedback_input, .current_sense_pos,
    .current_sense_neg, .feedback_drive_output, .vbus_load_switch, .dp_probe_in, .legacy_sig_out,
    .pd_sink_resp_in, .pd_cable_5a_in, .pd_evt_valid_in, .pd_evt_type_in, .pd_req_mv_in,
    .pd_req_ma_in, .pd_src_caps_out, .pd_accept_out, .pd_reject_out, .pd_adv_pdp_w_out,
    .pd_adv_max_ma_out, .adc_start_out, .adc_chan_vcc_out, .adc_done_in, .adc_data_in,
    .pps_reply_valid_out, .pps_reply_curr_out, .pps_reply_volt_out);
  pdsap_sink_model u_sink (.clk_in(sys_clk_in), .rst_n_in, .attach_in(attach), .both_rd_in(both),
    .answer_in(answer), .lat_in(lat), .i_code_in(i_code), .v_code_in(v_code),
    .src_caps_in(pd_src_caps_out), .adc_start_in(adc_start_out), .adc_chan_vcc_in(adc_chan_vcc_out),
    .cc_rd_out(cc_rd_in), .resp_out(pd_sink_resp_in), .adc_done_out(adc_done_in),
    .adc_data_out(adc_data_in));
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask
  // The request is held until the edge at which waitrequest is seen low.
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] wd);
    int k;
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_writedata_in <= wd;
    k = 0;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 50);
    if (k == 50) mismatches++;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wait_sw(input logic v, input int mx);
    n = 0;
    @(negedge sys_clk_in);
    while (vbus_load_switch !== v && n < mx) begin
      @(negedge sys_clk_in);
      n++;
    end
  endtask
  task automatic evt(input logic [1:0] t, input logic [15:0] mv, input logic [12:0] ma);
    @(posedge sys_clk_in);
    pd_evt_valid_in <= 1'b1;
    pd_evt_type_in <= pdsap_evt_t'(t);
    pd_req_mv_in <= mv;
    pd_req_ma_in <= ma;
    @(posedge sys_clk_in);
    pd_evt_valid_in <= 1'b0;
    @(negedge sys_clk_in);
  endtask
  always @(posedge sys_clk_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0 && rd_q.size() > 0) begin
      check("readdata", rd_q.pop_front(), avs_readdata_out);
    end
    if (pps_reply_valid_out === 1'b1 && pps_q.size() > 0) begin
      check("pps_curr", {22'h0, pps_q[0][9:0]}, {22'h0, pps_reply_curr_out});
      check("pps_volt", {22'h0, pps_q[0][19:10]}, {22'h0, pps_reply_volt_out});
      void'(pps_q.pop_front());
    end
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(93012));
    trim_pdp_w_in = 7'(16 + $urandom % 85);
    trim_cable_comp_in = 2'($urandom);
    trim_ovp_in = 2'($urandom);
    tv = {18'h0, 1'b1, trim_ovp_in, 1'b1, trim_cable_comp_in, 1'b0, trim_pdp_w_in};
    tick(5);
    rst_n_in <= 1'b1;
    rd(`PDSAP_REG_STATUS, 32'h0000_0101);
    rd(`PDSAP_REG_TRIM, tv);
    bus(`PDSAP_REG_TRIM, 1'b1, 32'h0);
    rd(`PDSAP_REG_TRIM, tv);
    rd(5'h18, 32'h0);
    check("pullup", 32'h3, {30'h0, cc_pullup_3a_out});
    check("adv_pdp", {25'h0, trim_pdp_w_in}, {25'h0, pd_adv_pdp_w_out});
    check("adv_ma", 32'd3000, {19'h0, pd_adv_max_ma_out});
    both <= 1'b1;
    attach <= 1'b1;
    wait_sw(1'b1, 1100);
    check("sw_both", 32'h0, {31'h0, vbus_load_switch});
    tick(1);
    both <= 1'b0;
    vcc_mv_in <= 16'd4700;
    wait_sw(1'b1, 1100);
    check("sw_vcc", 32'h0, {31'h0, vbus_load_switch});
    bus(`PDSAP_REG_IRQ_MASK, 1'b1, 32'h1);
    answer <= 1'b1;
    vcc_mv_in <= 16'd5000;
    wait_sw(1'b1, 1200);
    check("attach_delay", 32'h1, {31'h0, n >= 999 && n <= 1003});
    check("irq_set", 32'h1, {31'h0, irq_out});
    bus(`PDSAP_REG_IRQ_STAT, 1'b1, 32'h1);
    @(negedge sys_clk_in);
    check("irq_clr", 32'h0, {31'h0, irq_out});
    tick(5);
    rd(`PDSAP_REG_STATUS, 32'h0000_2308);
    for (int k = 0; k < 4; k++) begin
      evt(2'(k / 2 + 1), k[0] ? 16'd3000 + 16'(k) * 16'd6000 : 16'd9000 - 16'(k) * 16'd2000,
          k[0] ? 13'd1000 + 13'(k) * 13'd667 : 13'd3000 - 13'(k) * 13'd500);
      check("accept", {31'h0, k != 3}, {31'h0, pd_accept_out});
      check("reject", {31'h0, k == 3}, {31'h0, pd_reject_out});
    end
    rd(`PDSAP_REG_CONTRACT, {3'h0, 13'd2000, 16'd5000});
    for (int k = 0; k < 2; k++) begin
      lat <= 4'(k * 7);
      i_code <= 10'($urandom);
      v_code <= 10'($urandom);
      tick(1);
      pps_q.push_back({v_code, i_code});
      evt(2'h3, 16'h0, 13'h0);
      n = 0;
      while (pps_q.size() > 0 && n < 100) begin
        @(negedge sys_clk_in);
        n++;
      end
      check("pps_wait", 32'h0, pps_q.size());
    end
    tick(1);
    voltage_feedback_input <= 16'd600;
    tick(60);
    d = feedback_drive_output;
    voltage_feedback_input <= 16'd400;
    tick(60);
    check("drive_dir", 32'h1, {31'h0, d > feedback_drive_output});
    voltage_feedback_input <= 16'd500;
    attach <= 1'b0;
    wait_sw(1'b0, 50);
    check("detach", 32'h0, {31'h0, vbus_load_switch});
    tick(5);
    answer <= 1'b0;
    dp_probe_in <= 1'b1;
    attach <= 1'b1;
    wait_sw(1'b1, 1200);
    tick(NR + 50);
    rd(`PDSAP_REG_STATUS, 32'h0000_1310);
    current_sense_pos <= 13'd3500;
    wait_sw(1'b0, 50);
    check("ocp", 32'h0, {31'h0, vbus_load_switch});
    complete_run();
  end
endmodule
`default_nettype wire
